// ---- rtl/vmrd_regs.sv ----
// Vector-magnitude debounce count and initial reference registers.
// Assumes byte writes/reads from the serial core and an ODR period count in
// clock cycles with acceleration data from the datapath on the same clock.
//
// Contract
// - Debounce count is eight bits, read/write, whole register, reset zero.
// - Debounce period equals count times one effective output-data-rate period.
// - Temperature output enabled halves the effective rate for debounce timing.
// - X reference is signed 14 bits, high six bits then low byte.
// - Y reference is signed 14 bits split six high, eight low.
// - Z reference is signed 14 bits split six high, eight low.
// - Programmed references use the output data resolution of the range.
// - Programmed source loads init values on enable, else captures outputs.
// - Programmed source with no-update makes init registers live references.
// - Below threshold, counter decrements if mode zero, clears if one.
`timescale 1ns/1ps
`default_nettype none
`include "vmrd_defs.svh"
module vmrd_regs
    import vmrd_pkg::*;
#(
    parameter int DW = `VMRD_DIV_WIDTH
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register access
    input wire vmrd_wr_t reg_wr,
    input wire logic [7:0] reg_raddr,
    output logic [7:0] reg_rdata,
    // Detector controls from the config and threshold registers
    input wire logic func_en,
    input wire logic init_mode,
    input wire logic upd_mode,
    input wire logic dbcnt_mode,
    input wire logic above_ths,
    // Rate
    input wire logic [DW-1:0] odr_period_cycles,
    input wire logic temp_out_en,
    // Acceleration data at the output resolution
    input wire vmrd_xyz_t accel,
    // Results
    output vmrd_xyz_t ref_xyz,
    output logic event_active,
    output logic [7:0] debounce_state
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic [5:0] hi [3];
    logic [7:0] lo [3];
    logic en_d;
    vmrd_state_t state;
    logic odr_tick;

    function automatic logic [7:0] high_ofs(input int i);
        high_ofs = `VMRD_OFS_INIT_X_HIGH + 8'(2 * i);
    endfunction

    // Programmed references; bits 7:6 are never stored
    wire signed [13:0] init_x = {hi[0], lo[0]};
    wire signed [13:0] init_y = {hi[1], lo[1]};
    wire signed [13:0] init_z = {hi[2], lo[2]};
    wire vmrd_xyz_t init_xyz = '{x: init_x, y: init_y, z: init_z};
    wire enable_rise = func_en && !en_d;
    wire live_init = init_mode && upd_mode;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cnt_reg <= `VMRD_RST_BYTE;
        else if (reg_wr.wr && reg_wr.addr == `VMRD_OFS_DEBOUNCE_COUNT)
            cnt_reg <= reg_wr.wdata;
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    hi[g] <= 6'h00;
                    lo[g] <= `VMRD_RST_BYTE;
                end
                else if (reg_wr.wr)
                begin
                    if (reg_wr.addr == high_ofs(g))
                        hi[g] <= reg_wr.wdata[`VMRD_HIGH_MSB:0];
                    if (reg_wr.addr == high_ofs(g) + 8'h01)
                        lo[g] <= reg_wr.wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_raddr)
            `VMRD_OFS_DEBOUNCE_COUNT: next_rdata = cnt_reg;
            `VMRD_OFS_INIT_X_HIGH: next_rdata = {2'b00, hi[0]};
            `VMRD_OFS_INIT_X_LOW: next_rdata = lo[0];
            `VMRD_OFS_INIT_Y_HIGH: next_rdata = {2'b00, hi[1]};
            `VMRD_OFS_INIT_Y_LOW: next_rdata = lo[1];
            `VMRD_OFS_INIT_Z_HIGH: next_rdata = {2'b00, hi[2]};
            `VMRD_OFS_INIT_Z_LOW: next_rdata = lo[2];
            default: next_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Effective rate tick
    // ------------------------------------------------------------
    vmrd_rate_tick #(.DW(DW)) u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .period_cycles(odr_period_cycles),
        .temp_out_en(temp_out_en),
        .odr_tick(odr_tick)
    );

    // ------------------------------------------------------------
    // Reference selection and debounce
    // ------------------------------------------------------------
    // Debounce counter advances once per effective ODR period
    wire reached = (debounce_state >= cnt_reg);
    wire [7:0] dec_val = (debounce_state == 8'h00) ? 8'h00 : debounce_state - 8'h01;
    // Below threshold: clear or step down by one per the mode bit
    wire [7:0] below_val = dbcnt_mode ? 8'h00 : dec_val;
    wire [7:0] above_val = reached ? debounce_state : debounce_state + 8'h01;
    wire [7:0] next_count = above_ths ? above_val : below_val;
    // Nine bits so a saturated count of 255 keeps the event standing
    wire [8:0] above_sum = {1'b0, debounce_state} + 9'h001;
    wire next_event = above_ths ? (above_sum >= {1'b0, cnt_reg})
        : (below_val >= cnt_reg && below_val != 8'h00 && event_active);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            en_d <= 1'b0;
            state <= VMRD_IDLE;
            ref_xyz <= '0;
            event_active <= 1'b0;
            debounce_state <= 8'h00;
            reg_rdata <= 8'h00;
        end
        else
        begin
            en_d <= func_en;
            reg_rdata <= next_rdata;
            case (state)
                VMRD_IDLE:
                begin
                    event_active <= 1'b0;
                    debounce_state <= 8'h00;
                    if (enable_rise)
                    begin
                        // Programmed values or a snapshot of the outputs
                        ref_xyz <= init_mode ? init_xyz : accel;
                        state <= VMRD_RUN;
                    end
                end
                VMRD_RUN:
                begin
                    if (!func_en)
                        state <= VMRD_IDLE;
                    else
                    begin
                        // Host may rewrite references at any time in this mode
                        if (live_init)
                            ref_xyz <= init_xyz;
                        if (odr_tick)
                        begin
                            debounce_state <= next_count;
                            event_active <= next_event;
                            // Re-reference on a trigger unless no-update is set
                            if (next_event && !event_active && !upd_mode)
                                ref_xyz <= accel;
                        end
                    end
                end
                default: state <= VMRD_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/vmrd_defs.svh ----
// Offsets, field positions, reset values and widths of the
// vector-magnitude reference and debounce register bank.
// Assumes byte-wide register access from the serial interface core.
`ifndef VMRD_DEFS_SVH
`define VMRD_DEFS_SVH
`define VMRD_OFS_DEBOUNCE_COUNT 8'h62
`define VMRD_OFS_INIT_X_HIGH 8'h63
`define VMRD_OFS_INIT_X_LOW 8'h64
`define VMRD_OFS_INIT_Y_HIGH 8'h65
`define VMRD_OFS_INIT_Y_LOW 8'h66
`define VMRD_OFS_INIT_Z_HIGH 8'h67
`define VMRD_OFS_INIT_Z_LOW 8'h68
`define VMRD_RST_BYTE 8'h00
`define VMRD_HIGH_MSB 5
`define VMRD_HIGH_WIDTH 6
`define VMRD_AXIS_WIDTH 14
`define VMRD_DIV_WIDTH 24
`endif

// ---- rtl/vmrd_pkg.sv ----
// Types shared by the vector-magnitude reference and debounce bank.
// Assumes the constants header is included by each user.
`default_nettype none
package vmrd_pkg;
    // Register write strobe from the serial interface core
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vmrd_wr_t;
    // One sample of the three axes
    typedef struct packed {
        logic signed [13:0] x;
        logic signed [13:0] y;
        logic signed [13:0] z;
    } vmrd_xyz_t;
    typedef enum logic [1:0] {
        VMRD_IDLE = 2'b00,
        VMRD_RUN = 2'b01
    } vmrd_state_t;
endpackage
`default_nettype wire

// ---- rtl/vmrd_rate_tick.sv ----
// Output-data-rate tick divider for the debounce timer.
// Assumes period_cycles is the selected ODR period in ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "vmrd_defs.svh"
module vmrd_rate_tick
    import vmrd_pkg::*;
#(
    parameter int DW = `VMRD_DIV_WIDTH
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Rate selection
    input wire logic [DW-1:0] period_cycles,
    input wire logic temp_out_en,
    // Tick
    output logic odr_tick
);
    logic [DW-1:0] cnt;
    logic half_phase;
    wire cnt_wrap = (cnt >= period_cycles - {{(DW-1){1'b0}}, 1'b1}) || (period_cycles == '0);
    // Temperature output halves the effective rate: only every other wrap counts
    wire eff_tick = cnt_wrap && (!temp_out_en || half_phase);
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            half_phase <= 1'b0;
            odr_tick <= 1'b0;
        end
        else
        begin
            cnt <= cnt_wrap ? '0 : cnt + {{(DW-1){1'b0}}, 1'b1};
            if (cnt_wrap)
                half_phase <= !half_phase;
            odr_tick <= eff_tick;
        end
    end
endmodule
`default_nettype wire

// ---- sim/vmrd_monitor.sv ----
// Port checker for the reference and debounce bank.
// Assumes ODR ticks come at most six clocks apart.
`timescale 1ns/1ps
`default_nettype none
module vmrd_monitor
    import vmrd_pkg::*;
(
    // Clock, reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Watched ports
    input wire vmrd_wr_t reg_wr,
    input wire logic [7:0] reg_raddr,
    input wire logic [7:0] reg_rdata,
    input wire logic func_en,
    input wire logic init_mode,
    input wire logic upd_mode,
    input wire logic dbcnt_mode,
    input wire logic above_ths,
    input wire vmrd_xyz_t accel,
    input wire vmrd_xyz_t ref_xyz,
    input wire logic [7:0] debounce_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_live; (func_en && init_mode && upd_mode)[*3]; endsequence
    a_unmapped_zero: assert property (
        !(reg_raddr inside {[8'h62:8'h68]}) |=> reg_rdata == 8'h00) else $error("bad read");
    a_high_bits_zero: assert property (
        reg_raddr inside {8'h63, 8'h65, 8'h67} |=> reg_rdata[7:6] == 2'b00) else $error("bad hi");
    a_capture_ref: assert property (
        $rose(func_en) && !init_mode |=> ref_xyz == $past(accel)) else $error("no cap");
    a_live_ref: assert property (s_live ##0 (reg_wr.wr && reg_wr.addr == 8'h64)
        ##1 (func_en && init_mode && upd_mode)
        |=> ref_xyz.x[7:0] == $past(reg_wr.wdata, 2)) else $error("not live");
    a_below_no_rise: assert property (
        (func_en && !above_ths)[*3] |-> debounce_state <= $past(debounce_state))
        else $error("up");
    a_above_no_fall: assert property (
        (func_en && above_ths)[*3] |-> debounce_state >= $past(debounce_state))
        else $error("down");
    a_step_one: assert property (
        {1'b0, debounce_state} <= {1'b0, $past(debounce_state)} + 9'h001) else $error("jump");
    a_clear_mode: assert property (
        (func_en && dbcnt_mode && !above_ths)[*8] |-> debounce_state == 8'h00)
        else $error("no clr");
endmodule
`default_nettype wire

// ---- sim/vmrd_host.sv ----
// Host model: byte writes and reads on the register port.
// Assumes read data comes one clock after the address.
`timescale 1ns/1ps
`default_nettype none
module vmrd_host
    import vmrd_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output vmrd_wr_t reg_wr,
    output logic [7:0] reg_raddr,
    input wire logic [7:0] reg_rdata
);
    initial reg_wr = '0;
    initial reg_raddr = 8'h00;
    // Rewrites may come at any time, also while references are live
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= '{1'b1, a, v};
        @(posedge ref_clk);
        reg_wr <= '{1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_raddr <= a;
        repeat (2) @(posedge ref_clk);
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- sim/vmrd_regs_tb.sv ----
// Bench: register access, references, debounce timing; LFSR data.
// Assumes host model and checker compiled first; ODR period 3 clocks.
`timescale 1ns/1ps
`default_nettype none
module vmrd_regs_tb
    import vmrd_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, func_en = 1'b0, init_mode = 1'b0, upd_mode = 1'b0;
    logic dbcnt_mode = 1'b1, above_ths = 1'b0, temp_out_en = 1'b0, event_active;
    logic [7:0] reg_raddr, reg_rdata, debounce_state, d, r [7];
    logic [31:0] lfsr = 32'h7787;
    vmrd_wr_t reg_wr;
    vmrd_xyz_t accel = '0, ref_xyz;
    int num_errors = 0, compares = 0, cycles = 0, t0;
    vmrd_regs i_vmrd_regs (.ref_clk, .rst_n, .reg_wr, .reg_raddr, .reg_rdata, .func_en,
        .init_mode, .upd_mode, .dbcnt_mode, .above_ths, .odr_period_cycles(24'h000003),
        .temp_out_en, .accel, .ref_xyz, .event_active, .debounce_state);
    vmrd_host i_vmrd_host (.ref_clk, .reg_wr, .reg_raddr, .reg_rdata);
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (++cycles == 2000)
            complete_run(1);
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] expect_byte(input int idx, input logic [7:0] v);
        return idx[0] ? (v & 8'h3f) : v;
    endfunction
    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        compares++;
        num_errors += int'(got !== exp);
        if (got !== exp)
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic complete_run(input int hung);
        num_errors += hung;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        i_vmrd_host.wr(8'h69, 8'hff);
        for (int a = 8'h60; a < 8'h6a; a++)
        begin
            i_vmrd_host.rd(8'(a), d);
            chk(42'(d), 42'h0);
        end
        for (int a = 0; a < 7; a++)
        begin
            lfsr = next_rand(lfsr);
            d = lfsr[7:0] | (a[0] ? 8'hc0 : 8'h00);
            r[a] = expect_byte(a, d);
            i_vmrd_host.wr(8'h62 + 8'(a), d);
            i_vmrd_host.rd(8'h62 + 8'(a), d);
            chk(42'(d), 42'(r[a]));
        end
        $display("register test done");
        {func_en, init_mode, upd_mode} <= 3'b111;
        repeat (4) @(posedge ref_clk);
        chk(ref_xyz, {r[1][5:0], r[2], r[3][5:0], r[4], r[5][5:0], r[6]});
        r[2] = lfsr[15:8];
        i_vmrd_host.wr(8'h64, r[2]);
        repeat (3) @(posedge ref_clk);
        chk({28'h0, ref_xyz.x}, {28'h0, r[1][5:0], r[2]});
        {func_en, init_mode, upd_mode} <= 3'b000;
        accel <= {lfsr[20:0], lfsr[31:11]};
        repeat (3) @(posedge ref_clk);
        func_en <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(ref_xyz, accel);
        $display("reference test done");
        i_vmrd_host.wr(8'h62, 8'h04);
        for (int t = 1; t < 3; t++)
        begin
            temp_out_en <= t[1];
            dbcnt_mode <= t[0];
            above_ths <= 1'b1;
            t0 = cycles;
            while (event_active !== 1'b1 && cycles < t0 + 200)
                @(posedge ref_clk);
            chk(42'(cycles - t0 >= 9 * t && cycles - t0 <= 12 * t + 4), 42'h1);
            above_ths <= 1'b0;
            repeat (3 * t + 2) @(posedge ref_clk);
            chk(42'(debounce_state == 8'h00), 42'(t[0]));
        end
        $display("debounce test done");
        complete_run(0);
    end
endmodule
bind vmrd_regs vmrd_monitor i_vmrd_monitor (.ref_clk, .rst_n, .reg_wr, .reg_raddr,
    .reg_rdata, .func_en, .init_mode, .upd_mode, .dbcnt_mode, .above_ths, .accel,
    .ref_xyz, .debounce_state);
`default_nettype wire
